// ### bench/ddrcd_datapath_tb_top.sv
/*
 self-checking bench for the ddr command encoder and datapath.
 assumes ddrcd_mem_model stands on the memory pins, one strobe group.
*/
module ddrcd_datapath_tb_top import ddrcd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0;
   ddrcd_cmd_t  cmd_code = DDRCD_NOP;
   logic [1:0]  cmd_bank = 2'h0, local_be = 2'h0;
   logic [12:0] cmd_addr = 13'h0, open_row, mem_addr;
   logic        cfg_ddr2 = 1'b0, cfg_burst_type = 1'b0, local_wdata_valid = 1'b0;
   logic [2:0]  cfg_cas_lat = 3'h2, cfg_burst_len = 3'h2;
   logic [15:0] local_wdata = 16'h0, local_rdata;
   logic [3:0]  bank_open;
   logic        local_wdata_ready, local_rdata_valid, wr_stb;
   logic        mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
   logic [1:0]  mem_ba;
   logic [7:0]  mem_dq_i, mem_dq_rise_o, mem_dq_fall_o, mem_dq_oe, mdl_dq, errs;
   logic        mem_dm_rise_o, mem_dm_fall_o, mem_dqs_oe, mem_dqs_o;
   logic [17:0] wr_word, cap_q[$];
   int          failures = 0, samples_checked = 0, l2, l3, l3b, l5;

   // two-way data wire resolved from both parties
   assign mem_dq_i = (mem_dq_oe & (clk ? mem_dq_rise_o : mem_dq_fall_o)) | (~mem_dq_oe & mdl_dq);

   ddrcd_datapath ddrcd_datapath_i (.clk, .rst_n, .cmd_valid, .cmd_code, .cmd_bank,
      .cmd_addr, .cfg_ddr2, .cfg_cas_lat, .cfg_burst_len, .cfg_burst_type, .bank_open,
      .open_row, .local_wdata_valid, .local_wdata_ready, .local_wdata, .local_be,
      .local_rdata, .local_rdata_valid, .mem_cs_n, .mem_ras_n, .mem_cas_n, .mem_we_n,
      .mem_ba, .mem_addr, .mem_dq_i, .mem_dq_rise_o, .mem_dq_fall_o, .mem_dq_oe,
      .mem_dm_rise_o, .mem_dm_fall_o, .mem_dqs_o, .mem_dqs_oe);

   ddrcd_mem_model ddrcd_mem_model_i (.clk, .cs_n(mem_cs_n), .ras_n(mem_ras_n),
      .cas_n(mem_cas_n), .we_n(mem_we_n), .ba(mem_ba), .addr(mem_addr),
      .dq_oe(mem_dq_oe[0]), .dq(mdl_dq), .wr_word, .wr_stb, .errs,
      .wr_beat({mem_dm_fall_o, mem_dm_rise_o, mem_dq_fall_o, mem_dq_rise_o}));

   always #5 clk = ~clk;
   always @(posedge clk) if (wr_stb) cap_q.push_back(wr_word);

   // ================================================================
   // shared tasks
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      if (failures == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // returns in the cycle where the pins show the command
   task automatic issue(input ddrcd_cmd_t code, input logic [1:0] bank, input logic [12:0] a);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = code;
      cmd_bank = bank;
      cmd_addr = a;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_code = DDRCD_NOP;
   endtask

   task automatic mode(input logic ddr2, input logic [2:0] cl, input logic [2:0] bl);
      @(negedge clk);
      cfg_ddr2 = ddr2;
      cfg_cas_lat = cl;
      cfg_burst_len = bl;
      issue(DDRCD_LMR, 2'h0, 13'h0);
      check("mode word", {25'h0, cl, cfg_burst_type, bl}, {19'h0, mem_addr});
   endtask

   task automatic wr_burst(input int dly, input int words);
      int first, n_dq, n_dqs, n_hi;
      first = -1;
      n_hi = 0;
      n_dq = 0;
      n_dqs = 0;
      issue(DDRCD_WR, 2'h3, 13'h0);
      for (int i = 1; i < 24; i++) begin
         @(negedge clk);
         if (mem_dq_oe[0] === 1'b1 && first < 0) first = i;
         if (mem_dq_oe[0] === 1'b1) n_dq++;
         if (mem_dqs_oe === 1'b1) n_dqs++;
         if (mem_dqs_o === 1'b1) n_hi++;
      end
      check("write active delay", 32'(dly), 32'(first));
      check("dq drive cycles", 32'(words), 32'(n_dq));
      check("strobe drive cycles", 32'(words + 1), 32'(n_dqs));
      check("strobe toggled", 32'h1, 32'(n_hi > 0));
   endtask

   // ================================================================
   // scenarios
   task automatic t_reset();
      check("cs_n in reset", 32'h1, {31'h0, mem_cs_n});
      check("bank_open in reset", 32'h0, {28'h0, bank_open});
      check("oe in reset", 32'h0, {23'h0, mem_dq_oe, mem_dqs_oe});
      check("ready in reset", 32'h1, {31'h0, local_wdata_ready});
   endtask

   task automatic t_encode();
      ddrcd_cmd_t codes[7] = '{DDRCD_LMR, DDRCD_ACT, DDRCD_RD, DDRCD_WR, DDRCD_BT,
                               DDRCD_PCH, DDRCD_ARF};
      foreach (codes[k]) begin
         issue(codes[k], 2'h0, 13'h0a5);
         check("command pins", {29'h0, codes[k]},
               {28'h0, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n});
         @(negedge clk);
         check("idle pins", 32'h1, {31'h0, mem_cs_n | (mem_ras_n & mem_cas_n & mem_we_n)});
      end
      // a code without valid must not reach the pins
      cmd_code = DDRCD_RD;
      repeat (2) @(negedge clk);
      check("unqualified code", 32'h1,
            {31'h0, mem_cs_n | (mem_ras_n & mem_cas_n & mem_we_n)});
      cmd_code = DDRCD_NOP;
      repeat (30) @(negedge clk);
   endtask

   task automatic t_bank();
      issue(DDRCD_ACT, 2'h2, 13'h1abc);
      check("activate address", {17'h0, 2'h2, 13'h1abc}, {17'h0, mem_ba, mem_addr});
      @(negedge clk);
      check("bank open", 32'h4, {28'h0, bank_open});
      check("open row", 32'h1abc, {19'h0, open_row});
      issue(DDRCD_PCH, 2'h2, 13'h0);
      @(negedge clk);
      check("bank closed", 32'h0, {28'h0, bank_open});
      issue(DDRCD_ACT, 2'h2, 13'h0123);
      @(negedge clk);
      check("reopened row", 32'h0123, {19'h0, open_row});
   endtask

   task automatic t_read(input logic ddr2, input logic [2:0] cl, input logic [2:0] bl,
                         output int lat);
      int got;
      got = 0;
      lat = -1;
      mode(ddr2, cl, bl);
      issue(DDRCD_ACT, 2'h1, 13'h0);
      issue(DDRCD_RD, 2'h1, 13'h040);
      for (int i = 1; i < 40; i++) begin
         @(negedge clk);
         if (local_rdata_valid === 1'b1) begin
            if (lat < 0) lat = i;
            check("read word",
                  {16'h0, 8'h41 + 8'(2 * got), 8'h40 + 8'(2 * got)}, {16'h0, local_rdata});
            got++;
         end
      end
      check("read words", 32'(1 << (bl - 3'h1)), 32'(got));
   endtask

   task automatic t_fifo();
      for (int k = 0; k < 17; k++) begin
         @(negedge clk);
         check("wdata ready", (k < 16) ? 32'h1 : 32'h0, {31'h0, local_wdata_ready});
         local_wdata_valid = 1'b1;
         local_wdata = {8'hb0 + 8'(k), 8'ha0 + 8'(k)};
         local_be = 2'(k);
      end
      @(negedge clk);
      local_wdata_valid = 1'b0;
      cfg_burst_type = 1'b1;
      mode(1'b0, 3'h2, 3'h3);
      issue(DDRCD_ACT, 2'h3, 13'h0);
      cap_q.delete();
      repeat (5) wr_burst(2, 4);
      check("ready after drain", 32'h1, {31'h0, local_wdata_ready});
      check("write beats", 32'd20, 32'(cap_q.size()));
      for (int k = 0; k < 20; k++) begin
         // the fifo ran dry after 16: the last word is sent again
         int w = (k < 16) ? k : 15;
         check("write beat",
               {14'h0, ~2'(w), 8'hb0 + 8'(w), 8'ha0 + 8'(w)}, {14'h0, cap_q[k]});
      end
   endtask

   // ================================================================
   // main sequence
   initial begin
      repeat (4) @(negedge clk);
      t_reset();
      rst_n = 1'b1;
      t_encode();
      t_bank();
      t_read(1'b0, 3'h2, 3'h1, l2);
      t_read(1'b0, 3'h3, 3'h2, l3);
      t_read(1'b1, 3'h3, 3'h3, l3b);
      t_read(1'b1, 3'h5, 3'h2, l5);
      check("latency step ddr", 32'h1, 32'(l3 - l2));
      check("latency step ddr2", 32'h2, 32'(l5 - l3b));
      t_fifo();
      mode(1'b1, 3'h4, 3'h1);
      @(negedge clk);
      local_wdata_valid = 1'b1;
      @(negedge clk);
      local_wdata_valid = 1'b0;
      wr_burst(4, 1);
      check("memory protocol errors", 32'h0, {24'h0, errs});
      conclude();
   end

   initial begin
      #50us;
      failures++;
      conclude();
   end
endmodule

// ### bench/ddrcd_mem_model.sv
/*
 behavioural memory for the datapath bench: bank state, mode word,
 read bursts on both clock edges and capture of driven write beats.
 assumes the command pins are sampled on the rising system clock edge.
*/
`include "ddrcd_params.svh"

module ddrcd_mem_model (
   // clock
   input  wire logic        clk,
   // command pins
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic [1:0]  ba,
   input  wire logic [12:0] addr,
   // data pins
   input  wire logic        dq_oe,
   input  wire logic [17:0] wr_beat,
   output logic      [7:0]  dq,
   // observation
   output logic      [17:0] wr_word,
   output logic             wr_stb,
   output logic      [7:0]  errs
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0] cl_r;
   logic [3:0] beats_r;
   logic [3:0] open_r;

   initial begin
      cl_r = 3'h2;
      beats_r = 4'h1;
      open_r = 4'h0;
      errs = 8'h00;
      wr_stb = 1'b0;
      wr_word = 18'h0;
      dq = 8'h5a;
   end

   // ================================================================
   // read burst
   task automatic burst(input logic [7:0] base);
      logic [3:0] n;
      n = beats_r;
      repeat (cl_r - 3'h1) @(posedge clk);
      for (int j = 0; j < n; j++) begin
         @(negedge clk) #1 dq = base + 8'(2 * j);
         @(posedge clk) #1 dq = base + 8'(2 * j + 1);
      end
      // released bus shows the inverse, so a late capture cannot match
      @(negedge clk) #1 dq = ~dq;
   endtask

   // ================================================================
   // command decode
   always @(posedge clk) begin
      wr_stb <= dq_oe;
      wr_word <= wr_beat;
      if (!cs_n) begin
         case ({ras_n, cas_n, we_n})
            `DDRCD_CMD_ACT: open_r[ba] <= 1'b1;
            `DDRCD_CMD_PCH: open_r[ba] <= 1'b0;
            `DDRCD_CMD_LMR: begin
               cl_r <= addr[6:4];
               beats_r <= 4'h1 << (addr[2:0] - 3'h1);
            end
            `DDRCD_CMD_RD: begin
               if (!open_r[ba]) errs <= errs + 8'h01;
               fork burst(addr[7:0]); join_none
            end
            `DDRCD_CMD_WR: if (!open_r[ba]) errs <= errs + 8'h01;
            default: ;
         endcase
      end
   end
endmodule

// ### common/ddrcd_params.svh
/*
 constants for the ddr command encoder and datapath: command levels,
 mode word layout, latencies and buffer sizes.
 assumes it is included by bare name from package and design files.
*/
`ifndef DDRCD_PARAMS_SVH
`define DDRCD_PARAMS_SVH
`define DDRCD_CMD_NOP   3'h7
`define DDRCD_CMD_ACT   3'h3
`define DDRCD_CMD_RD    3'h5
`define DDRCD_CMD_WR    3'h4
`define DDRCD_CMD_BT    3'h6
`define DDRCD_CMD_PCH   3'h2
`define DDRCD_CMD_ARF   3'h1
`define DDRCD_CMD_LMR   3'h0
`define DDRCD_MR_BL_LSB 0
`define DDRCD_MR_BT_BIT 3
`define DDRCD_MR_CL_LSB 4
`define DDRCD_BL2       3'h1
`define DDRCD_BL4       3'h2
`define DDRCD_BL8       3'h3
`define DDRCD_CL_MAX    5
`define DDRCD_DDR2_WL_OFS 2
`define DDRCD_GRP_LOCAL 16
`define DDRCD_GRP_MEM   8
`define DDRCD_FIFO_DEPTH 16
`define DDRCD_RESYNC    2
`endif

// ### common/ddrcd_pkg.sv
/*
 types shared by the ddr command encoder and datapath.
 assumes ddrcd_params.svh sits on the include path.
*/
`include "ddrcd_params.svh"
package ddrcd_pkg;
   typedef enum logic [2:0] {
      DDRCD_NOP = `DDRCD_CMD_NOP,
      DDRCD_ACT = `DDRCD_CMD_ACT,
      DDRCD_RD  = `DDRCD_CMD_RD,
      DDRCD_WR  = `DDRCD_CMD_WR,
      DDRCD_BT  = `DDRCD_CMD_BT,
      DDRCD_PCH = `DDRCD_CMD_PCH,
      DDRCD_ARF = `DDRCD_CMD_ARF,
      DDRCD_LMR = `DDRCD_CMD_LMR
   } ddrcd_cmd_t;
   typedef enum logic [1:0] {
      DDRCD_WS_IDLE  = 2'h0,
      DDRCD_WS_BURST = 2'h1,
      DDRCD_WS_TAIL  = 2'h3
   } ddrcd_ws_t;
endpackage

// ### logic/ddrcd_datapath.sv
/*
 ddr command encoder, bank tracker and strobe-group datapath, with a
 write data fifo ahead of the write registers.
 assumes one system clock; pad cells outside turn the rise/fall pairs
 into double-rate pins and fold the enables into the two-way wires.
*/
`include "ddrcd_params.svh"

// ====================================================================
// fifo
module ddrcd_fifo import ddrcd_pkg::*; #(
   parameter int WIDTH = 16,
   parameter int DEPTH = `DDRCD_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rp_r];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop)  rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ====================================================================
// command encoder and datapath
module ddrcd_datapath import ddrcd_pkg::*; #(
   parameter int GROUPS  = 1,
   parameter int ROW_W   = 13,
   parameter int BANK_W  = 2,
   parameter int RESYNC  = `DDRCD_RESYNC
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // command request
   input  wire logic                    cmd_valid,
   input  ddrcd_cmd_t                   cmd_code,
   input  wire logic [BANK_W-1:0]       cmd_bank,
   input  wire logic [ROW_W-1:0]        cmd_addr,
   // configuration
   input  wire logic                    cfg_ddr2,
   input  wire logic [2:0]              cfg_cas_lat,
   input  wire logic [2:0]              cfg_burst_len,
   input  wire logic                    cfg_burst_type,
   // bank state
   output logic [(1<<BANK_W)-1:0]       bank_open,
   output logic [ROW_W-1:0]             open_row,
   // local write data
   input  wire logic                    local_wdata_valid,
   output logic                         local_wdata_ready,
   input  wire logic [GROUPS*16-1:0]    local_wdata,
   input  wire logic [GROUPS*2-1:0]     local_be,
   // local read data
   output logic [GROUPS*16-1:0]         local_rdata,
   output logic                         local_rdata_valid,
   // memory command pins
   output logic                         mem_cs_n,
   output logic                         mem_ras_n,
   output logic                         mem_cas_n,
   output logic                         mem_we_n,
   output logic [BANK_W-1:0]            mem_ba,
   output logic [ROW_W-1:0]             mem_addr,
   // memory data pins
   input  wire logic [GROUPS*8-1:0]     mem_dq_i,
   output logic [GROUPS*8-1:0]          mem_dq_rise_o,
   output logic [GROUPS*8-1:0]          mem_dq_fall_o,
   output logic [GROUPS*8-1:0]          mem_dq_oe,
   output logic [GROUPS-1:0]            mem_dm_rise_o,
   output logic [GROUPS-1:0]            mem_dm_fall_o,
   output logic [GROUPS-1:0]            mem_dqs_o,
   output logic [GROUPS-1:0]            mem_dqs_oe
);
   localparam int LW = GROUPS * `DDRCD_GRP_LOCAL;
   localparam int MW = GROUPS * `DDRCD_GRP_MEM;
   localparam int PL = `DDRCD_CL_MAX + 1;

   function automatic logic [2:0] beats_of(input logic [2:0] bl);
      unique case (bl)
         `DDRCD_BL2: beats_of = 3'h1;
         `DDRCD_BL4: beats_of = 3'h2;
         default:    beats_of = 3'h4;
      endcase
   endfunction

   // ==================================================================
   // command encoding
   logic         cmd_go;
   logic [2:0]   beats;
   assign cmd_go = cmd_valid && cmd_code != DDRCD_NOP;
   assign beats  = beats_of(cfg_burst_len);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mem_cs_n  <= 1'b1;
         mem_ras_n <= 1'b1;
         mem_cas_n <= 1'b1;
         mem_we_n  <= 1'b1;
         mem_ba    <= '0;
         mem_addr  <= '0;
      end else begin
         mem_cs_n <= !cmd_go;
         {mem_ras_n, mem_cas_n, mem_we_n} <= cmd_go ? cmd_code : DDRCD_NOP;
         mem_ba <= cmd_bank;
         if (cmd_code == DDRCD_LMR) begin
            mem_addr <= '0;
            mem_addr[`DDRCD_MR_BL_LSB +: 3] <= cfg_burst_len;
            mem_addr[`DDRCD_MR_BT_BIT]      <= cfg_burst_type;
            mem_addr[`DDRCD_MR_CL_LSB +: 3] <= cfg_cas_lat;
         end else begin
            mem_addr <= cmd_addr;
         end
      end
   end

   // ==================================================================
   // bank tracking; the controller still decides when to precharge
   logic [ROW_W-1:0] row_tbl [1<<BANK_W];
   assign open_row = row_tbl[cmd_bank];

   always_ff @(posedge clk) begin
      if (cmd_go && cmd_code == DDRCD_ACT) begin
         row_tbl[cmd_bank] <= cmd_addr;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bank_open <= '0;
      end else if (cmd_go && cmd_code == DDRCD_ACT) begin
         bank_open[cmd_bank] <= 1'b1;
      end else if (cmd_go && cmd_code == DDRCD_PCH) begin
         bank_open[cmd_bank] <= 1'b0;
      end
   end

   // ==================================================================
   // burst counters, cut short by burst terminate
   logic [2:0] rd_cnt_r;
   logic [2:0] wr_cnt_r;
   logic       rd_act;
   logic       wr_act;
   assign rd_act = (rd_cnt_r != 3'h0);
   assign wr_act = (wr_cnt_r != 3'h0);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_cnt_r <= 3'h0;
         wr_cnt_r <= 3'h0;
      end else if (cmd_go && cmd_code == DDRCD_BT) begin
         rd_cnt_r <= 3'h0;
         wr_cnt_r <= 3'h0;
      end else begin
         rd_cnt_r <= (cmd_go && cmd_code == DDRCD_RD) ? beats
                   : rd_act ? rd_cnt_r - 3'h1 : 3'h0;
         wr_cnt_r <= (cmd_go && cmd_code == DDRCD_WR) ? beats
                   : wr_act ? wr_cnt_r - 3'h1 : 3'h0;
      end
   end

   // ==================================================================
   // latency pipelines: tap k trails the command on the pins by k+1 cycles
   logic [PL-1:0] rd_pipe_r;
   logic [PL-1:0] wr_pipe_r;
   logic          rd_capt;
   logic          rd_rise_en;
   logic          doing_wr;
   logic [2:0]    wl;
   assign wl       = cfg_ddr2 ? cfg_cas_lat - 3'(`DDRCD_DDR2_WL_OFS) : 3'h0;
   assign rd_capt  = rd_pipe_r[cfg_cas_lat];
   // rising beat lands half a cycle before its falling partner
   assign rd_rise_en = rd_pipe_r[cfg_cas_lat - 3'h1];
   assign doing_wr = wr_pipe_r[wl];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_pipe_r <= '0;
         wr_pipe_r <= '0;
      end else begin
         rd_pipe_r <= {rd_pipe_r[PL-2:0], rd_act};
         wr_pipe_r <= {wr_pipe_r[PL-2:0], wr_act};
      end
   end

   // ==================================================================
   // write path: fifo, then registers gated by write data valid
   logic [LW+GROUPS*2-1:0] fifo_q;
   logic                   fifo_vld;
   logic                   wdata_valid;
   logic [LW-1:0]          wdata_r;
   logic [GROUPS*2-1:0]    wbe_r;
   // starved fifo leaves the old word; the controller must prefill it
   assign wdata_valid = doing_wr && fifo_vld;

   ddrcd_fifo #(.WIDTH(LW + GROUPS*2), .DEPTH(`DDRCD_FIFO_DEPTH)) u_wfifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (local_wdata_valid),
      .in_ready  (local_wdata_ready),
      .in_data   ({local_be, local_wdata}),
      .out_valid (fifo_vld),
      .out_ready (doing_wr),
      .out_data  (fifo_q)
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wdata_r <= '0;
         wbe_r   <= '0;
      end else if (wdata_valid) begin
         {wbe_r, wdata_r} <= fifo_q;
      end
   end

   // strobe state: burst, then one extra tail cycle
   ddrcd_ws_t ws_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ws_r <= DDRCD_WS_IDLE;
      end else begin
         unique case (ws_r)
            DDRCD_WS_IDLE:  ws_r <= doing_wr ? DDRCD_WS_BURST : DDRCD_WS_IDLE;
            DDRCD_WS_BURST: ws_r <= doing_wr ? DDRCD_WS_BURST : DDRCD_WS_TAIL;
            DDRCD_WS_TAIL:  ws_r <= doing_wr ? DDRCD_WS_BURST : DDRCD_WS_IDLE;
            default:        ws_r <= DDRCD_WS_IDLE;
         endcase
      end
   end

   // ==================================================================
   // strobe groups: 16 local bits over 8 memory bits each
   logic [LW-1:0] rdata_cap;
   logic [MW-1:0] dq_fall_cap_r;
   logic          dq_oe_r;

   // one clock only: the 90 degree write clock is the pad cell's job
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dq_oe_r <= 1'b0;
      end else begin
         dq_oe_r <= doing_wr;
      end
   end

   always_ff @(negedge clk) begin
      if (!rst_n) begin
         dq_fall_cap_r <= '0;
      end else if (rd_capt) begin
         dq_fall_cap_r <= mem_dq_i;
      end
   end

   genvar g;
   generate
      for (g = 0; g < GROUPS; g++) begin : gen_grp
         logic [7:0] rise_r;
         logic       dqs_r;
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               rise_r <= '0;
            end else if (rd_rise_en) begin
               rise_r <= mem_dq_i[g*8 +: 8];
            end
         end
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               dqs_r <= 1'b0;
            end else begin
               dqs_r <= (ws_r == DDRCD_WS_BURST) && !dqs_r;
            end
         end
         assign rdata_cap[g*16 +: 16] = {dq_fall_cap_r[g*8 +: 8], rise_r};
         assign mem_dq_rise_o[g*8 +: 8] = wdata_r[g*16 +: 8];
         assign mem_dq_fall_o[g*8 +: 8] = wdata_r[g*16+8 +: 8];
         assign mem_dm_rise_o[g] = !wbe_r[g*2];
         assign mem_dm_fall_o[g] = !wbe_r[g*2+1];
         assign mem_dq_oe[g*8 +: 8] = {8{dq_oe_r}};
         assign mem_dqs_o[g] = dqs_r;
         assign mem_dqs_oe[g] = (ws_r != DDRCD_WS_IDLE);
      end
   endgenerate

   // ==================================================================
   // resynchronisation chain to the system clock
   logic [LW-1:0] rs_d_r [RESYNC+1];
   logic [RESYNC:0] rs_v_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rs_v_r <= '0;
      end else begin
         rs_v_r <= {rs_v_r[RESYNC-1:0], rd_capt};
      end
   end
   always_ff @(posedge clk) begin
      rs_d_r[0] <= rdata_cap;
      for (int i = 1; i <= RESYNC; i++) begin
         rs_d_r[i] <= rs_d_r[i-1];
      end
   end
   assign local_rdata       = rs_d_r[RESYNC];
   assign local_rdata_valid = rs_v_r[RESYNC];

   // ==================================================================
   // checks
   property p_nop_when_idle;
      @(posedge clk) disable iff (!rst_n)
      !cmd_go |=> mem_cs_n && {mem_ras_n, mem_cas_n, mem_we_n} == 3'h7;
   endproperty
   a_nop_when_idle: assert property (p_nop_when_idle) else $error("idle not nop");

   property p_cmd_code;
      @(posedge clk) disable iff (!rst_n)
      cmd_go |=> !mem_cs_n && {mem_ras_n, mem_cas_n, mem_we_n} == $past(cmd_code);
   endproperty
   a_cmd_code: assert property (p_cmd_code) else $error("command levels wrong");

   property p_act_opens;
      @(posedge clk) disable iff (!rst_n)
      cmd_go && cmd_code == DDRCD_ACT |=> bank_open[$past(cmd_bank)]
         && row_tbl[$past(cmd_bank)] == $past(cmd_addr);
   endproperty
   a_act_opens: assert property (p_act_opens) else $error("activate not tracked");

   property p_pch_closes;
      @(posedge clk) disable iff (!rst_n)
      cmd_go && cmd_code == DDRCD_PCH |=> !bank_open[$past(cmd_bank)];
   endproperty
   a_pch_closes: assert property (p_pch_closes) else $error("precharge left bank open");

   property p_bl4_beats;
      @(posedge clk) disable iff (!rst_n)
      cmd_go && cmd_code == DDRCD_RD && cfg_burst_len == `DDRCD_BL4
         ##1 !(cmd_go && cmd_code inside {DDRCD_BT, DDRCD_RD}) [*2]
         |-> rd_act ##1 !rd_act;
   endproperty
   a_bl4_beats: assert property (p_bl4_beats) else $error("bl4 beat count wrong");

   property p_rd_latency;
      @(posedge clk) disable iff (!rst_n)
      $rose(rd_act) && $stable(cfg_cas_lat) && cfg_cas_lat == 3'h3 |-> ##3 rd_rise_en;
   endproperty
   a_rd_latency: assert property (p_rd_latency) else $error("cas latency off");

   property p_wdata_gate;
      @(posedge clk) disable iff (!rst_n)
      !wdata_valid |=> $stable(wdata_r);
   endproperty
   a_wdata_gate: assert property (p_wdata_gate) else $error("write regs moved ungated");

   property p_dqs_tail;
      @(posedge clk) disable iff (!rst_n)
      $fell(doing_wr) |=> mem_dqs_oe[0] ##1 !mem_dqs_oe[0] || doing_wr;
   endproperty
   a_dqs_tail: assert property (p_dqs_tail) else $error("strobe tail not one cycle");

   // valid leaves the last of RESYNC+1 stages
   localparam int RS_DLY = RESYNC + 1;
   property p_resync;
      @(posedge clk) disable iff (!rst_n)
      rd_capt |-> ##RS_DLY local_rdata_valid;
   endproperty
   a_resync: assert property (p_resync) else $error("resync depth wrong");

   c_read:  cover property (@(posedge clk) disable iff (!rst_n) $rose(local_rdata_valid));
   c_write: cover property (@(posedge clk) disable iff (!rst_n) $fell(mem_dqs_oe[0]));
   c_bt:    cover property (@(posedge clk) disable iff (!rst_n)
                            rd_act && cmd_go && cmd_code == DDRCD_BT);
   c_full:  cover property (@(posedge clk) disable iff (!rst_n) !local_wdata_ready);
endmodule
